// ---- rtl/pspsl_map.svh ----
// Constants for the power-switch protection and status logic.
// Assumes a 25 MHz ref_clk; analog comparators arrive as synchronous levels.
`ifndef PSPSL_MAP_SVH
`define PSPSL_MAP_SVH

`define PSPSL_CLK_MHZ 25
`define PSPSL_PWM_HZ 9000
`define PSPSL_PWM_PERIOD (`PSPSL_CLK_MHZ * 1000000 / `PSPSL_PWM_HZ)
`define PSPSL_MIN_PULSE_NS 30
`define PSPSL_MIN_PULSE_CYC ((`PSPSL_MIN_PULSE_NS * `PSPSL_CLK_MHZ + 999) / 1000)
`define PSPSL_DUTY_LO_PCT 3
`define PSPSL_DUTY_HI_PCT 82
`define PSPSL_TEMP_LO_C 25
`define PSPSL_TEMP_HI_C 150
`define PSPSL_OT_TRIP_C 175
`define PSPSL_OT_CLEAR_C 160
`define PSPSL_BLANK_NS 200
`define PSPSL_BLANK_CYC ((`PSPSL_BLANK_NS * `PSPSL_CLK_MHZ + 999) / 1000)
`define PSPSL_SLEW_FAST 8'h96
`define PSPSL_SLEW_MID 8'h64
`define PSPSL_SLEW_SLOW 8'h0F
`define PSPSL_FILT_SHIFT 6
`define PSPSL_RES_MAX 8'hFF

`endif

// ---- rtl/pspsl_pkg.sv ----
// Types for the power-switch protection and status logic.
// Assumes pspsl_map.svh supplies the numeric constants.
package pspsl_pkg;
  typedef enum logic [1:0] {
    PSPSL_PIN_RES,
    PSPSL_PIN_GND,
    PSPSL_PIN_RAIL,
    PSPSL_PIN_OPEN
  } pspsl_pin_e;
  typedef enum logic [1:0] {
    PSPSL_ST_IDLE,
    PSPSL_ST_BLANK,
    PSPSL_ST_WATCH,
    PSPSL_ST_COND
  } pspsl_dem_e;
endpackage : pspsl_pkg

// ---- rtl/pspsl_pwm.sv ----
// Thermal PWM generator.
// Assumes temp_c is the sensed die temperature in whole degrees, synchronous to ref_clk.
`timescale 1ns/100ps
`include "pspsl_map.svh"
module pspsl_pwm import pspsl_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] temp_c,
  input wire logic over_temp,
  output logic pwm_out
);
  localparam int PER = `PSPSL_PWM_PERIOD;
  localparam int MINW = `PSPSL_MIN_PULSE_CYC;
  localparam int WLO = PER * `PSPSL_DUTY_LO_PCT / 100;
  localparam int WHI = PER * `PSPSL_DUTY_HI_PCT / 100;
  localparam int SPAN = `PSPSL_TEMP_HI_C - `PSPSL_TEMP_LO_C;
  logic [11:0] cnt;
  logic [11:0] width;
  logic [11:0] next_width;
  logic [31:0] above;
  logic [31:0] lin;
  wire period_end = (cnt == 12'(PER - 1));
  // Minimum pulse at or below the low endpoint, linear above it through the top and beyond, clamped below the period
  assign above = (32'(temp_c) > 32'(`PSPSL_TEMP_LO_C)) ?
                 32'(temp_c) - 32'(`PSPSL_TEMP_LO_C) : 32'h0;
  assign lin = 32'(WLO) + above * 32'(WHI - WLO) / 32'(SPAN);
  always_comb begin
    if (temp_c <= 8'(`PSPSL_TEMP_LO_C)) begin
      next_width = 12'(MINW);
    end else if (lin >= 32'(PER - 1)) begin
      next_width = 12'(PER - 1);
    end else if (lin < 32'(MINW)) begin
      next_width = 12'(MINW);
    end else begin
      next_width = lin[11:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 12'h000;
      width <= 12'(MINW);
      pwm_out <= 1'b0;
    end else begin
      cnt <= period_end ? 12'h000 : cnt + 12'h001;
      if (period_end) begin
        width <= next_width; // refresh once a period
      end
      pwm_out <= over_temp | (cnt < width);
    end
  end
  // Width never drops below the minimum, so every period opens with a pulse
  min_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt == 12'h000 |=> pwm_out)
    else $error("thermal pulse missing at period start");
  ot_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    over_temp |=> pwm_out)
    else $error("thermal output not high during overtemperature");
  period_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    period_end |=> cnt == 12'h000)
    else $error("pwm period counter did not wrap");
endmodule : pspsl_pwm

// ---- rtl/pspsl_dem.sv ----
// Diode-emulation state machine used during thermal shutdown.
// Assumes drain comparators are synchronous levels; gate_fall is a one-cycle pulse.
`timescale 1ns/100ps
`include "pspsl_map.svh"
module pspsl_dem import pspsl_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic gate_fall,
  input wire logic drain_neg,
  input wire logic drain_fwd_i,
  output logic switch_on,
  output pspsl_dem_e state
);
  localparam int BLK = `PSPSL_BLANK_CYC;
  pspsl_dem_e next_state;
  logic [7:0] blank;
  always_comb begin
    next_state = state;
    unique case (state)
      PSPSL_ST_IDLE: next_state = active ? PSPSL_ST_WATCH : PSPSL_ST_IDLE;
      PSPSL_ST_BLANK: next_state = (blank == 8'(BLK - 1)) ? PSPSL_ST_WATCH : state;
      PSPSL_ST_WATCH: next_state = drain_neg ? PSPSL_ST_COND : state;
      PSPSL_ST_COND: next_state = drain_fwd_i ? PSPSL_ST_WATCH : state;
    endcase
    if (!active) begin
      next_state = PSPSL_ST_IDLE;
    end else if (gate_fall) begin
      next_state = PSPSL_ST_BLANK;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PSPSL_ST_IDLE;
      blank <= 8'h00;
    end else begin
      state <= next_state;
      // A new gate fall restarts the blank time
      blank <= (state == PSPSL_ST_BLANK && next_state == PSPSL_ST_BLANK && !gate_fall) ?
               blank + 8'h01 : 8'h00;
    end
  end
  assign switch_on = (state == PSPSL_ST_COND);
  fall_blank_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    active && gate_fall |=> state == PSPSL_ST_BLANK)
    else $error("gate fall did not enter blank state");
  blank_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state == PSPSL_ST_BLANK) |-> ##[1:8] (state != PSPSL_ST_BLANK))
    else $error("blank state overran");
  start_watch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == PSPSL_ST_IDLE && active && !gate_fall |=> state == PSPSL_ST_WATCH)
    else $error("shutdown entry not in watch state");
  cond_on_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == PSPSL_ST_WATCH && drain_neg && active && !gate_fall |=> switch_on)
    else $error("negative drain did not turn switch on");
endmodule : pspsl_dem

// ---- rtl/pspsl_top.sv ----
// Protection and status logic of a power-switch driver: fault outputs,
// slew selection, thermal PWM and thermal-shutdown diode emulation.
// Assumes all sensing comparators and the gate command are synchronous to ref_clk.
`timescale 1ns/100ps
`include "pspsl_map.svh"
module pspsl_top import pspsl_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic gate_cmd,
  input wire logic supply_uv,
  input wire logic [7:0] die_temp_c,
  input wire logic overcurrent,
  input wire logic short_circuit,
  input wire logic drain_neg,
  input wire logic drain_fwd_i,
  input wire logic single_mode_strap,
  input wire pspsl_pin_e slew_pin_kind,
  input wire logic [7:0] slew_pin_res,
  output logic error_indicator_n,
  output logic overcurrent_indicator_n,
  output logic thermal_pwm_out,
  output logic [7:0] slew_code,
  output logic switch_on,
  output logic thermal_diode_emulation
);
  logic started;
  logic single_mode;
  logic rail_latched;
  logic open_pin;
  logic over_temp;
  logic gate_q;
  logic [13:0] filt;
  logic [7:0] next_slew;
  logic [7:0] res_slew;
  logic dem_on;
  logic err_cond;
  logic ovc_cond;
  pspsl_dem_e dem_state;
  wire gate_fall = gate_q & ~gate_cmd;
  wire [7:0] filt_res = filt[13:6];
  // Resistance maps linearly from slow to fast code; heavy filter rejects switching noise
  assign res_slew = 8'(`PSPSL_SLEW_SLOW) +
    8'((16'(filt_res) * 16'(`PSPSL_SLEW_FAST - `PSPSL_SLEW_SLOW)) / 16'(`PSPSL_RES_MAX));
  always_comb begin
    next_slew = slew_code;
    if (rail_latched) begin
      next_slew = 8'(`PSPSL_SLEW_MID);
    end else if (slew_pin_kind == PSPSL_PIN_GND) begin
      next_slew = 8'(`PSPSL_SLEW_FAST);
    end else if (slew_pin_kind == PSPSL_PIN_RES) begin
      next_slew = res_slew;
    end
  end
  // Open-pin error only while monitoring continues
  assign err_cond = supply_uv | over_temp | open_pin | short_circuit;
  assign ovc_cond = overcurrent | short_circuit;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
      single_mode <= 1'b0;
      rail_latched <= 1'b0;
      open_pin <= 1'b0;
      over_temp <= 1'b0;
      gate_q <= 1'b0;
      filt <= 14'h0000;
      slew_code <= 8'(`PSPSL_SLEW_FAST);
      error_indicator_n <= 1'b0;
      overcurrent_indicator_n <= 1'b1;
    end else begin
      started <= 1'b1;
      gate_q <= gate_cmd;
      if (!started) begin
        // Strap and rail tie are sampled once, at the first edge after release
        single_mode <= single_mode_strap;
        rail_latched <= (slew_pin_kind == PSPSL_PIN_RAIL);
      end
      filt <= filt - 14'(filt >> `PSPSL_FILT_SHIFT) + 14'(slew_pin_res);
      open_pin <= !rail_latched && started && (slew_pin_kind == PSPSL_PIN_OPEN);
      if (die_temp_c >= 8'(`PSPSL_OT_TRIP_C)) begin
        over_temp <= 1'b1;
      end else if (die_temp_c < 8'(`PSPSL_OT_CLEAR_C)) begin
        over_temp <= 1'b0;
      end
      slew_code <= next_slew;
      if (single_mode) begin
        error_indicator_n <= ~(err_cond | ovc_cond);
        overcurrent_indicator_n <= 1'b1;
      end else begin
        error_indicator_n <= ~err_cond;
        overcurrent_indicator_n <= ~ovc_cond;
      end
    end
  end
  pspsl_pwm u_pwm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .temp_c(die_temp_c),
    .over_temp(over_temp),
    .pwm_out(thermal_pwm_out)
  );
  pspsl_dem u_dem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .active(over_temp),
    .gate_fall(gate_fall),
    .drain_neg(drain_neg),
    .drain_fwd_i(drain_fwd_i),
    .switch_on(dem_on),
    .state(dem_state)
  );
  assign thermal_diode_emulation = over_temp;
  // The controller is expected to switch this device first after shutdown entry
  assign switch_on = over_temp ? dem_on :
    (gate_cmd & ~open_pin & ~supply_uv & ~short_circuit & ~overcurrent);
  single_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    started && single_mode && (supply_uv || overcurrent) |=> !error_indicator_n)
    else $error("single mode fault not on error output");
  dual_oc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    started && !single_mode && overcurrent && !err_cond |=>
    !overcurrent_indicator_n && error_indicator_n)
    else $error("dual mode overcurrent mapping wrong");
  gnd_fast_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rail_latched && slew_pin_kind == PSPSL_PIN_GND |=> slew_code == 8'h96)
    else $error("ground tie did not select fastest slew");
  rail_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rail_latched |=> slew_code == 8'h64 && rail_latched)
    else $error("latched rail setting changed");
  open_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    open_pin && !over_temp |-> !switch_on ##1 !error_indicator_n)
    else $error("open slew pin did not hold switch off");
  ot_hyst_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    over_temp && die_temp_c >= 8'(`PSPSL_OT_CLEAR_C) |=> over_temp)
    else $error("overtemperature cleared above hysteresis point");
  idle_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !over_temp |=> dem_state == PSPSL_ST_IDLE)
    else $error("emulation machine active outside shutdown");
endmodule : pspsl_top

// ---- test/pspsl_ctrl_model.sv ----
// Converter controller model: drives the gate command, toggling or held.
// Assumes the block's ref_clk; the command changes on a rising edge, seen one edge later.
`timescale 1ns/100ps
module pspsl_ctrl_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic hold_hi,
  input wire logic [7:0] half_len,
  output logic gate_cmd
);
  logic [7:0] cnt;
  // Switching this device first walks it through the blank state
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      gate_cmd <= 1'b0;
    end else if (!run) begin
      cnt <= 8'h00;
      gate_cmd <= hold_hi;
    end else begin
      cnt <= (cnt >= half_len) ? 8'h00 : cnt + 8'h01;
      if (cnt >= half_len) gate_cmd <= ~gate_cmd;
    end
  end
endmodule : pspsl_ctrl_model

// ---- test/power_switch_protection_status_logic_test.sv ----
// Self-checking bench for the protection and status logic.
// Assumes pspsl_ctrl_model drives gate_cmd; all other inputs come from here.
`timescale 1ns/100ps
`include "pspsl_map.svh"
module power_switch_protection_status_logic_test import pspsl_pkg::*;;
  localparam int PER = `PSPSL_PWM_PERIOD;
  localparam int BLANK = `PSPSL_BLANK_CYC;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic uv = 1'b0, ovc = 1'b0, sc = 1'b0, dneg = 1'b0, dfwd = 1'b0;
  logic strap = 1'b1, run = 1'b0, hold_hi = 1'b0;
  logic [7:0] temp = 8'h1E, res = 8'h80;
  pspsl_pin_e kind = PSPSL_PIN_RES;
  logic gate_cmd, err_n, ovc_n, pwm, sw, emu;
  logic [7:0] slew;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'hE1F6;
  always #20 ref_clk = ~ref_clk;
  pspsl_ctrl_model u_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .run(run),
    .hold_hi(hold_hi), .half_len(8'h28), .gate_cmd(gate_cmd));
  pspsl_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .gate_cmd(gate_cmd),
    .supply_uv(uv), .die_temp_c(temp), .overcurrent(ovc), .short_circuit(sc),
    .drain_neg(dneg), .drain_fwd_i(dfwd), .single_mode_strap(strap),
    .slew_pin_kind(kind), .slew_pin_res(res), .error_indicator_n(err_n),
    .overcurrent_indicator_n(ovc_n), .thermal_pwm_out(pwm), .slew_code(slew),
    .switch_on(sw), .thermal_diode_emulation(emu));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic near(input int a, input int b, input int tol);
    return (a >= b - tol) && (a <= b + tol);
  endfunction : near
  function automatic int exp_w(input int t);
    return PER * 3 / 100 + (PER * 82 / 100 - PER * 3 / 100) * (t - 25) / 125;
  endfunction : exp_w
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic do_reset(input logic s, input pspsl_pin_e k);
    rst_n = 1'b0;
    strap = s;
    kind = k;
    cyc(10);
    rst_n = 1'b1;
    cyc(4);
  endtask : do_reset
  task automatic wait_pwm(input logic v, output int c);
    c = 0;
    while (pwm !== v && c < 2 * PER) begin
      cyc(1);
      c++;
    end
  endtask : wait_pwm
  // Settle a new temperature, then measure one whole high pulse and period
  task automatic pulse(input logic [7:0] t, output int w, output int p);
    int c;
    temp = t;
    cyc(PER);
    wait_pwm(1'b0, c);
    wait_pwm(1'b1, c);
    wait_pwm(1'b0, w);
    wait_pwm(1'b1, c);
    p = w + c;
  endtask : pulse
  task automatic lows(output int n);
    n = 0;
    repeat (PER) begin
      cyc(1);
      if (pwm !== 1'b1) n++;
    end
  endtask : lows
  task automatic faults(input logic dual);
    for (int f = 0; f < 5; f++) begin
      uv = (f == 0);
      temp = (f == 1) ? 8'hB4 : 8'h1E;
      kind = (f == 2) ? PSPSL_PIN_OPEN : PSPSL_PIN_RES;
      ovc = (f == 3);
      sc = (f == 4);
      cyc(4);
      check("err_n fault", err_n, dual && f == 3);
      check("ovc_n fault", ovc_n, !(dual && f >= 3));
      if (f == 2) check("switch open pin", sw, 1'b0);
    end
    sc = 1'b0;
    cyc(4);
    check("err_n clear", err_n, 1'b1);
    check("switch clear", sw, 1'b1);
  endtask : faults
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    int w, p, n, t;
    logic [7:0] r;
    do_reset(1'b1, PSPSL_PIN_RES);
    hold_hi = 1'b1;
    faults(1'b0);
    kind = PSPSL_PIN_GND;
    cyc(4);
    check("slew ground", slew, 8'h96);
    kind = PSPSL_PIN_RES;
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd();
      res = r;
      cyc(3);
      // Heavy filtering keeps a full-scale step from landing at once
      if (i == 1) check("slew filtered", slew < 8'h40, 1'b1);
      cyc(1500);
      check("slew resistor", near(slew, 15 + r * 135 / 255, 2), 1'b1);
    end
    do_reset(1'b1, PSPSL_PIN_RAIL);
    check("slew rail", slew, 8'h64);
    kind = PSPSL_PIN_OPEN;
    cyc(4);
    check("rail pin ignored", slew, 8'h64);
    check("rail open no error", err_n, 1'b1);
    do_reset(1'b0, PSPSL_PIN_RES);
    faults(1'b1);
    hold_hi = 1'b0;
    pulse(8'h0A, w, p);
    check("pwm min width", w, 1);
    check("pwm period", near(p, PER, 2), 1'b1);
    t = 26 + rnd() % 124;
    pulse(t[7:0], w, p);
    check("pwm linear", near(w, exp_w(t), 30), 1'b1);
    pulse(8'h96, w, p);
    check("pwm top", near(w, exp_w(150), 30), 1'b1);
    pulse(8'hAA, w, p);
    check("pwm above range", near(w, exp_w(170), 30), 1'b1);
    temp = 8'hB4;
    cyc(4);
    check("emulation on", emu, 1'b1);
    check("enter watch off", sw, 1'b0);
    dneg = 1'b1;
    cyc(3);
    check("conduct on", sw, 1'b1);
    dneg = 1'b0;
    dfwd = 1'b1;
    cyc(3);
    check("forward off", sw, 1'b0);
    dfwd = 1'b0;
    dneg = 1'b1;
    cyc(3);
    check("conduct again", sw, 1'b1);
    run = 1'b1;
    n = 0;
    while (gate_cmd !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    while (gate_cmd === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    cyc(3);
    check("fall turns off", sw, 1'b0);
    n = 3;
    while (sw !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    check("blank span", near(n, BLANK + 2, 2), 1'b1);
    run = 1'b0;
    lows(n);
    check("pwm held high", n, 0);
    temp = 8'hA5;
    lows(n);
    check("pwm hysteresis", n, 0);
    temp = 8'h64;
    cyc(PER);
    lows(n);
    check("pwm resumes", n > 0, 1'b1);
    check("emulation off", emu, 1'b0);
    conclude();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
endmodule : power_switch_protection_status_logic_test
